// ===== rtl/lm_port_link_mgr.sv
/*
  Link manager for one switch port: retraining, link-down handling, credit
  advertisement, slot power limit messages, hardware ASPM and status outputs.
  Assumes register accesses, link events and packet events are all synchronous
  to CORE_CLK and that event inputs are one-cycle pulses.
*/
`default_nettype none
module lm_port_link_mgr
  import lm_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter int EXP_PER_CYC = EXP_PERIOD_CYC,
  parameter int ACT_HOLD_CYC = EXP_PERIODS * EXP_PER_CYC
) (
  input wire logic CORE_CLK, // Core clock, 100 MHz.
  input wire logic SYS_RST, // Asynchronous reset, active high.
  input wire logic [ADDR_W-1:0] REG_ADDR, // Register byte address.
  input wire logic [DATA_W-1:0] REG_WDATA, // Register write data.
  input wire logic REG_WR, // Write strobe.
  input wire logic REG_RD, // Read strobe.
  output logic [DATA_W-1:0] REG_RDATA, // Read data, valid the cycle after REG_RD.
  input wire logic TRAIN_DONE, // Training finished, link may enter L0.
  input wire logic RECOV_DONE, // Recovery finished.
  input wire logic LINK_FAIL, // Physical link lost.
  input wire logic L0S_COND, // L0s entry conditions met.
  input wire logic L1_COND, // L1 entry conditions met.
  input wire logic IDLE_EXIT, // Traffic pending, leave L0s or L1.
  input wire logic L1_ACK, // Partner accepts the L1 request.
  input wire logic L1_NAK, // Partner rejects the L1 request.
  input wire logic TURNOFF_ACKED, // Turn-off message acknowledged.
  input wire logic RX_SPL_VALID, // Slot power limit message received.
  input wire logic [7:0] RX_SPL_BYTE0, // Payload byte 0.
  input wire logic [7:0] RX_SPL_BYTE1, // Payload byte 1.
  input wire logic TX_TLP, // Packet transmitted.
  input wire logic TX_VDM, // That packet is a vendor defined message.
  input wire logic RX_TLP, // Packet received.
  input wire logic RX_VDM, // That packet is a vendor defined message.
  output logic RETRAIN_START, // Pulse: enter Recovery now.
  output logic L1_REQ, // L1 request pending toward partner.
  output logic QUEUE_FLUSH, // Pulse: drop packets queued from this port.
  output logic ROUTE_UR, // Level: packets routed here are UR.
  output logic CFG_ACCEPT, // Level: bridge configuration accepted.
  output logic FC_ADV, // Pulse: advertise credits.
  output logic [7:0] FC_CREDITS, // Credits to advertise.
  output logic TRAFFIC_HOLD, // Level: no TLP or DLLP may cross.
  output logic TX_SPL, // Pulse: send slot power limit message.
  output logic [7:0] TX_SPL_SCALE, // Message byte 0.
  output logic [1:0] TX_SPL_VALUE, // Message byte 1 bits 1:0.
  output logic PORT_LINK_UP_STATUS_N, // Link up, active low.
  output logic PORT_ACTIVITY_STATUS_N // Activity, active low.
);

  function automatic logic lm_is_up(input lm_state_type s);
    lm_is_up = (s == ST_L0) || (s == ST_L0S) || (s == ST_L1) || (s == ST_RECOV);
  endfunction : lm_is_up

  lm_state_type state_r, state_nxt;
  logic [1:0] aspm_r;
  logic unlock_r;
  logic [7:0] cap_scale_r;
  logic [1:0] cap_value_r;
  logic [7:0] slot_scale_r;
  logic [1:0] slot_value_r;
  logic [TMR_W-1:0] l0s_tmr_r;
  logic [TMR_W-1:0] l1_tmr_r;
  logic d3hot_r;
  logic [7:0] credit_r;
  logic [TMR_W-1:0] l0s_cnt_r, l0s_cnt_nxt;
  logic [TMR_W-1:0] l1_cnt_r, l1_cnt_nxt;
  logic l1_pend_r;
  logic [ACT_CNT_W-1:0] act_cnt_r, act_cnt_nxt;
  logic act_r;
  logic [DATA_W-1:0] rdata_nxt;

  wire wr_lc = REG_WR && (REG_ADDR == OFS_LINK_CTRL);
  wire wr_sc = REG_WR && (REG_ADDR == OFS_SYS_CTRL);
  wire wr_slot = REG_WR && (REG_ADDR == OFS_SLOT_CAP);
  wire wr_pm = REG_WR && (REG_ADDR == OFS_PM_CTRL);
  wire wr_ps = REG_WR && (REG_ADDR == OFS_PM_STATE);
  wire wr_cr = REG_WR && (REG_ADDR == OFS_CREDIT);
  wire up_now = lm_is_up(state_r);
  wire up_nxt = lm_is_up(state_nxt);
  wire retrain_ok = !IS_UPSTREAM || unlock_r;
  wire retrain_go = wr_lc && REG_WDATA[LC_RETRAIN_BIT] && retrain_ok
                    && (state_r == ST_L0 || state_r == ST_L0S || state_r == ST_L1);
  wire in_l0_l0s = (state_r == ST_L0) || (state_r == ST_L0S);
  wire l0s_en = aspm_r[0];
  wire l1_en = aspm_r[1];
  wire l0s_hit = (state_r == ST_L0) && l0s_en && L0S_COND && (l0s_cnt_r == l0s_tmr_r);
  wire l1_hit = in_l0_l0s && l1_en && L1_COND && (l1_cnt_r == l1_tmr_r);
  // Only the upstream port ever raises an L1 request.
  wire l1_start = IS_UPSTREAM && !l1_pend_r && (l1_hit || (d3hot_r && in_l0_l0s));
  wire link_came_up = !up_now && up_nxt && (state_r == ST_DOWN);
  wire link_went_down = up_now && (state_nxt == ST_DOWN);
  wire spl_send = !IS_UPSTREAM && ((wr_slot && up_now) || link_came_up);
  wire act_evt = (TX_TLP && !TX_VDM) || (RX_TLP && !RX_VDM);

  // Link state sequencing; a retrain only changes state, never configuration.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_DOWN: begin
        if (TRAIN_DONE) begin
          state_nxt = ST_L0;
        end
      end
      ST_L0: begin
        if (LINK_FAIL) begin
          state_nxt = ST_DOWN;
        end else if (retrain_go) begin
          state_nxt = ST_RECOV;
        end else if (TURNOFF_ACKED) begin
          state_nxt = ST_L23;
        end else if (l1_pend_r && L1_ACK) begin
          state_nxt = ST_L1;
        end else if (l0s_hit && !l1_pend_r) begin
          state_nxt = ST_L0S;
        end
      end
      ST_L0S: begin
        if (LINK_FAIL) begin
          state_nxt = ST_DOWN;
        end else if (retrain_go) begin
          state_nxt = ST_RECOV;
        end else if (l1_pend_r && L1_ACK) begin
          state_nxt = ST_L1;
        end else if (IDLE_EXIT) begin
          state_nxt = ST_L0;
        end
      end
      ST_L1: begin
        if (LINK_FAIL) begin
          state_nxt = ST_DOWN;
        end else if (retrain_go || IDLE_EXIT) begin
          state_nxt = ST_RECOV;
        end
      end
      ST_RECOV: begin
        if (LINK_FAIL) begin
          state_nxt = ST_DOWN;
        end else if (RECOV_DONE) begin
          state_nxt = ST_L0;
        end
      end
      ST_L23: begin
        if (LINK_FAIL) begin
          state_nxt = ST_DOWN;
        end
      end
      default: begin
        state_nxt = ST_DOWN;
      end
    endcase
  end

  // Entry timers count only while their conditions hold without a break.
  always_comb begin
    l0s_cnt_nxt = '0;
    l1_cnt_nxt = '0;
    if ((state_r == ST_L0) && l0s_en && L0S_COND && !l0s_hit) begin
      l0s_cnt_nxt = l0s_cnt_r + 1'b1;
    end
    if (in_l0_l0s && l1_en && L1_COND && !l1_hit && !l1_pend_r) begin
      l1_cnt_nxt = l1_cnt_r + 1'b1;
    end
  end

  // The hold counter reloads on each packet that is not a vendor defined message, so quiet time alone ends it.
  always_comb begin
    act_cnt_nxt = act_cnt_r;
    if (act_evt) begin
      act_cnt_nxt = ACT_CNT_W'(ACT_HOLD_CYC - 1);
    end else if (act_cnt_r != '0) begin
      act_cnt_nxt = act_cnt_r - 1'b1;
    end
  end

  // Read mux; the retrain bit is self-clearing and reads as zero.
  always_comb begin
    rdata_nxt = '0;
    if (REG_RD) begin
      case (REG_ADDR)
        OFS_LINK_CTRL: rdata_nxt[LC_ASPM_LSB +: 2] = aspm_r;
        OFS_SYS_CTRL: rdata_nxt[SC_UNLOCK_BIT] = unlock_r;
        OFS_DEV_CAP: begin
          rdata_nxt[CAP_SCALE_LSB +: 8] = cap_scale_r;
          rdata_nxt[CAP_VALUE_LSB +: 2] = cap_value_r;
        end
        OFS_SLOT_CAP: begin
          rdata_nxt[CAP_SCALE_LSB +: 8] = slot_scale_r;
          rdata_nxt[CAP_VALUE_LSB +: 2] = slot_value_r;
        end
        OFS_PM_CTRL: begin
          rdata_nxt[PM_L0S_LSB +: TMR_W] = l0s_tmr_r;
          rdata_nxt[PM_L1_LSB +: TMR_W] = l1_tmr_r;
        end
        OFS_PM_STATE: rdata_nxt[PS_D3HOT_BIT] = d3hot_r;
        OFS_CREDIT: rdata_nxt[7:0] = credit_r;
        OFS_STATUS: begin
          rdata_nxt[ST_STATE_LSB +: 3] = state_r;
          rdata_nxt[ST_UP_BIT] = up_now;
          rdata_nxt[ST_ACT_BIT] = act_r;
          rdata_nxt[ST_L1PEND_BIT] = l1_pend_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= ST_DOWN;
      l0s_cnt_r <= '0;
      l1_cnt_r <= '0;
      act_cnt_r <= '0;
      REG_RDATA <= '0;
    end else begin
      state_r <= state_nxt;
      l0s_cnt_r <= l0s_cnt_nxt;
      l1_cnt_r <= l1_cnt_nxt;
      act_cnt_r <= act_cnt_nxt;
      REG_RDATA <= rdata_nxt;
    end
  end

  // Software settings; nothing here is touched by link events or retraining.
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aspm_r <= ASPM_RST;
      unlock_r <= 1'b0;
      slot_scale_r <= '0;
      slot_value_r <= '0;
      l0s_tmr_r <= L0S_TMR_RST;
      l1_tmr_r <= L1_TMR_RST;
      d3hot_r <= 1'b0;
      credit_r <= CREDIT_RST;
    end else begin
      if (wr_lc) begin
        aspm_r <= REG_WDATA[LC_ASPM_LSB +: 2];
      end
      if (wr_sc) begin
        unlock_r <= REG_WDATA[SC_UNLOCK_BIT];
      end
      if (wr_slot) begin
        slot_scale_r <= REG_WDATA[CAP_SCALE_LSB +: 8];
        slot_value_r <= REG_WDATA[CAP_VALUE_LSB +: 2];
      end
      if (wr_pm) begin
        l0s_tmr_r <= REG_WDATA[PM_L0S_LSB +: TMR_W];
        l1_tmr_r <= REG_WDATA[PM_L1_LSB +: TMR_W];
      end
      if (wr_ps) begin
        d3hot_r <= REG_WDATA[PS_D3HOT_BIT];
      end
      if (wr_cr) begin
        credit_r <= REG_WDATA[7:0];
      end
    end
  end

  // Captured power limit is only ever loaded by a received message.
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cap_scale_r <= '0;
      cap_value_r <= '0;
    end else if (IS_UPSTREAM && RX_SPL_VALID) begin
      cap_scale_r <= RX_SPL_BYTE0;
      cap_value_r <= RX_SPL_BYTE1[1:0];
    end
  end

  // A request waits for the partner's answer; a reject leaves the state alone.
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      l1_pend_r <= 1'b0;
    end else if (l1_pend_r && (L1_ACK || L1_NAK || !in_l0_l0s)) begin
      l1_pend_r <= 1'b0;
    end else if (l1_start) begin
      l1_pend_r <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RETRAIN_START <= 1'b0;
      L1_REQ <= 1'b0;
      QUEUE_FLUSH <= 1'b0;
      ROUTE_UR <= 1'b1;
      CFG_ACCEPT <= 1'b1;
      FC_ADV <= 1'b0;
      FC_CREDITS <= CREDIT_RST;
      TRAFFIC_HOLD <= 1'b0;
      TX_SPL <= 1'b0;
      TX_SPL_SCALE <= '0;
      TX_SPL_VALUE <= '0;
      act_r <= 1'b0;
      PORT_LINK_UP_STATUS_N <= 1'b1;
      PORT_ACTIVITY_STATUS_N <= 1'b1;
    end else begin
      RETRAIN_START <= retrain_go;
      L1_REQ <= IS_UPSTREAM && (l1_start || (l1_pend_r && !L1_ACK && !L1_NAK && in_l0_l0s));
      QUEUE_FLUSH <= link_went_down;
      ROUTE_UR <= !up_nxt;
      CFG_ACCEPT <= 1'b1;
      FC_ADV <= link_came_up;
      FC_CREDITS <= credit_r;
      TRAFFIC_HOLD <= (state_nxt == ST_L23);
      TX_SPL <= spl_send;
      TX_SPL_SCALE <= slot_scale_r;
      TX_SPL_VALUE <= slot_value_r;
      // Counting down to zero keeps the output low for the full hold, not one short.
      act_r <= act_evt || (act_cnt_r != '0);
      PORT_LINK_UP_STATUS_N <= !up_nxt;
      PORT_ACTIVITY_STATUS_N <= !(act_evt || (act_cnt_r != '0));
    end
  end

endmodule : lm_port_link_mgr
`default_nettype wire

// ===== rtl/lm_pkg.sv
/*
  Shared constants and types of the switch port link manager.
  Assumes a single 100 MHz core clock shared by every user of this package.
*/
`default_nettype none
package lm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TMR_W = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_LINK_CTRL = 8'h00;
  localparam logic [7:0] OFS_SYS_CTRL = 8'h04;
  localparam logic [7:0] OFS_DEV_CAP = 8'h08;
  localparam logic [7:0] OFS_SLOT_CAP = 8'h0c;
  localparam logic [7:0] OFS_PM_CTRL = 8'h10;
  localparam logic [7:0] OFS_PM_STATE = 8'h14;
  localparam logic [7:0] OFS_CREDIT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // Field positions.
  localparam int LC_ASPM_LSB = 0;
  localparam int LC_RETRAIN_BIT = 5;
  localparam int SC_UNLOCK_BIT = 0;
  localparam int CAP_SCALE_LSB = 0;
  localparam int CAP_VALUE_LSB = 8;
  localparam int PM_L0S_LSB = 0;
  localparam int PM_L1_LSB = 8;
  localparam int PS_D3HOT_BIT = 0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_UP_BIT = 4;
  localparam int ST_ACT_BIT = 5;
  localparam int ST_L1PEND_BIT = 6;

  // Reset values.
  localparam logic [1:0] ASPM_RST = 2'h0;
  localparam logic [TMR_W-1:0] L0S_TMR_RST = 8'h10;
  localparam logic [TMR_W-1:0] L1_TMR_RST = 8'h40;
  localparam logic [7:0] CREDIT_RST = 8'h20;

  // Timing.
  localparam int CLK_MHZ = 100;
  localparam int ACT_HOLD_MS = 200;
  localparam int EXP_PERIOD_MS = 40;
  localparam int EXP_PERIODS = ACT_HOLD_MS / EXP_PERIOD_MS;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int EXP_PERIOD_CYC = EXP_PERIOD_MS * CYC_PER_MS;
  localparam int ACT_CNT_W = 25;

  typedef enum logic [2:0] {
    ST_DOWN,
    ST_L0,
    ST_L0S,
    ST_L1,
    ST_RECOV,
    ST_L23
  } lm_state_type;
endpackage : lm_pkg
`default_nettype wire

// ===== testbench/lm_link_partner.sv
/*
  Link partner model: trains on command, ends Recovery, answers L1 requests.
  Assumes the bench drives train_go and nak_mode just after a rising edge.
*/
`default_nettype none
module lm_link_partner
  import lm_pkg::*;
(
  input wire logic CORE_CLK, // Core clock.
  input wire logic SYS_RST, // Reset, active high.
  input wire logic L1_REQ, // Pending L1 request.
  input wire logic RETRAIN_START, // Recovery entered by retrain.
  input wire logic IDLE_EXIT, // Recovery entered from L1.
  input wire logic train_go, // Bench asks for training.
  input wire logic nak_mode, // Refuse L1 requests.
  output logic TRAIN_DONE, // Training done.
  output logic RECOV_DONE, // Recovery done.
  output logic L1_ACK, // L1 accepted.
  output logic L1_NAK // L1 refused.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rec_r;
  logic [2:0] l1_r;
  // The answer comes late on purpose, so a pending request must hold.
  assign L1_ACK = L1_REQ && l1_r == 3'h4 && !nak_mode;
  assign L1_NAK = L1_REQ && l1_r == 3'h4 && nak_mode;
  assign RECOV_DONE = rec_r == 3'h3;
  assign TRAIN_DONE = train_go;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rec_r <= 3'h0;
      l1_r <= 3'h0;
    end else begin
      l1_r <= (L1_REQ && l1_r != 3'h4) ? l1_r + 3'h1 : 3'h0;
      rec_r <= (RETRAIN_START || IDLE_EXIT) ? 3'h1 : rec_r + {2'h0, rec_r != 3'h0};
    end
  end
endmodule : lm_link_partner
`default_nettype wire

// ===== testbench/lm_port_link_mgr_checker.sv
/*
  Checker for lm_port_link_mgr.
  Assumes one clock domain and the hold parameter of the bound instance.
*/
`default_nettype none
module lm_port_link_mgr_checker
  import lm_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter int ACT_HOLD_CYC = 100
) (
  input wire logic CORE_CLK, // Clock.
  input wire logic SYS_RST, // Reset.
  input wire logic LINK_FAIL, // Link lost.
  input wire logic TX_TLP, // Sent.
  input wire logic TX_VDM, // Sent vendor message.
  input wire logic RX_TLP, // Received.
  input wire logic RX_VDM, // Received vendor message.
  input wire logic L1_ACK, // Accept.
  input wire logic L1_NAK, // Reject.
  input wire logic L1_REQ, // Request.
  input wire logic QUEUE_FLUSH, // Flush.
  input wire logic ROUTE_UR, // Unsupported.
  input wire logic TRAFFIC_HOLD, // No traffic.
  input wire logic TX_SPL, // Send power limit.
  input wire logic PORT_LINK_UP_STATUS_N, // Up.
  input wire logic PORT_ACTIVITY_STATUS_N // Activity.
);
  logic [31:0] idle_r;
  wire logic qual = (TX_TLP && !TX_VDM) || (RX_TLP && !RX_VDM);
  // Saturates at the hold so idle stretches of any length stay cheap.
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      idle_r <= 32'(ACT_HOLD_CYC);
    end else if (qual) begin
      idle_r <= 32'h0;
    end else if (idle_r < 32'(ACT_HOLD_CYC)) begin
      idle_r <= idle_r + 32'h1;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_qual; qual; endsequence
  sequence s_drop; !PORT_LINK_UP_STATUS_N && LINK_FAIL; endsequence
  property p_flush; s_drop |=> QUEUE_FLUSH && PORT_LINK_UP_STATUS_N; endproperty
  a_flush: assert property (p_flush)
    else $error("no flush on link loss");
  property p_ur; ROUTE_UR == PORT_LINK_UP_STATUS_N; endproperty
  a_ur: assert property (p_ur)
    else $error("routing and link status disagree");
  property p_l23; TRAFFIC_HOLD |-> ROUTE_UR && PORT_LINK_UP_STATUS_N; endproperty
  a_l23: assert property (p_l23)
    else $error("traffic held while up");
  property p_role; IS_UPSTREAM ? !TX_SPL : !L1_REQ; endproperty
  a_role: assert property (p_role)
    else $error("request from wrong port side");
  property p_nak; L1_REQ && L1_NAK |=> !L1_REQ; endproperty
  a_nak: assert property (p_nak)
    else $error("request kept after refusal");
  property p_ack; L1_REQ && L1_ACK |=> !L1_REQ && !PORT_LINK_UP_STATUS_N; endproperty
  a_ack: assert property (p_ack)
    else $error("request kept after accept");
  property p_act; s_qual |=> !PORT_ACTIVITY_STATUS_N; endproperty
  a_act: assert property (p_act)
    else $error("activity not shown");
  property p_hold; idle_r < 32'(ACT_HOLD_CYC) |-> !PORT_ACTIVITY_STATUS_N; endproperty
  a_hold: assert property (p_hold)
    else $error("activity dropped early");
  property p_off; idle_r == 32'(ACT_HOLD_CYC) |-> PORT_ACTIVITY_STATUS_N; endproperty
  a_off: assert property (p_off)
    else $error("activity held too long");
endmodule : lm_port_link_mgr_checker
bind lm_port_link_mgr lm_port_link_mgr_checker #(
  .IS_UPSTREAM(IS_UPSTREAM), .ACT_HOLD_CYC(ACT_HOLD_CYC)) u_checker (.*);
`default_nettype wire

// ===== testbench/tb_lm_port_link_mgr.sv
/*
  Bench for an upstream lm_port_link_mgr beside a link partner model.
  Assumes the bound checker and a shortened expander period.
*/
`default_nettype none
module tb_lm_port_link_mgr;
  import lm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EP = 20;
  localparam int HOLD = EXP_PERIODS * EP;
  localparam int LIMIT = 5000;
  logic CORE_CLK, SYS_RST, REG_WR, REG_RD, LINK_FAIL, L0S_COND, L1_COND, IDLE_EXIT;
  logic TURNOFF_ACKED, RX_SPL_VALID, TX_TLP, TX_VDM, RX_TLP, RX_VDM, train_go, nak_mode;
  logic [ADDR_W-1:0] REG_ADDR;
  logic [DATA_W-1:0] REG_WDATA, REG_RDATA;
  logic [7:0] RX_SPL_BYTE0, RX_SPL_BYTE1, FC_CREDITS, TX_SPL_SCALE, cred;
  logic [1:0] TX_SPL_VALUE;
  logic TRAIN_DONE, RECOV_DONE, L1_ACK, L1_NAK, RETRAIN_START, L1_REQ, QUEUE_FLUSH;
  logic ROUTE_UR, CFG_ACCEPT, FC_ADV, TRAFFIC_HOLD, TX_SPL, rd_q;
  logic PORT_LINK_UP_STATUS_N, PORT_ACTIVITY_STATUS_N;
  logic [6:0] ev;
  logic [31:0] seed;
  logic [31:0] exp_q[$];
  int mismatches, total_checks, cyc;
  // One event vector keeps every pulse one cycle long and never doubled.
  assign {RX_TLP, TX_TLP, train_go, RX_SPL_VALID, TURNOFF_ACKED, IDLE_EXIT, LINK_FAIL} = ev;
  lm_port_link_mgr #(.EXP_PER_CYC(EP)) dut (.*);
  lm_link_partner u_partner (.*);
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic pulse(input logic [6:0] m);
    ev <= m;
    tick(1);
    ev <= 7'h0;
    tick(1);
  endtask : pulse
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    tick(1);
    REG_WR <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    tick(1);
    REG_RD <= 1'b0;
    tick(1);
  endtask : rd
  always @(posedge CORE_CLK) begin
    rd_q <= REG_RD;
    cyc <= cyc + 1;
    if (rd_q === 1'b1) chk(REG_RDATA, exp_q.pop_front());
    if (FC_ADV === 1'b1) chk({24'h0, FC_CREDITS}, {24'h0, cred});
    if (cyc == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    {REG_WR, REG_RD, L0S_COND, L1_COND, TX_VDM, RX_VDM, nak_mode, ev} = '0;
    {REG_ADDR, REG_WDATA, RX_SPL_BYTE0, RX_SPL_BYTE1} = '0;
    seed = 32'hc6e9;
    SYS_RST = 1'b1;
    tick(12);
    SYS_RST <= 1'b0;
    chk(ROUTE_UR & CFG_ACCEPT, 1'b1);
    rd(OFS_PM_CTRL, 32'h4010);
    rd(OFS_CREDIT, 32'h20);
    wr(8'h24, 32'hffff_ffff);
    rd(8'h24, 32'h0);
    seed = lfsr(seed);
    cred = seed[7:0];
    wr(OFS_CREDIT, {24'h0, cred});
    wr(OFS_PM_CTRL, 32'h0304);
    wr(OFS_LINK_CTRL, 32'h20);
    rd(OFS_STATUS, 32'h0);
    pulse(7'h10);
    rd(OFS_STATUS, 32'h11);
    chk(PORT_LINK_UP_STATUS_N, 1'b0);
    wr(OFS_LINK_CTRL, 32'h20);
    rd(OFS_STATUS, 32'h11);
    wr(OFS_SYS_CTRL, 32'h1);
    wr(OFS_LINK_CTRL, 32'h20);
    rd(OFS_STATUS, 32'h14);
    tick(4);
    rd(OFS_PM_CTRL, 32'h0304);
    rd(OFS_STATUS, 32'h11);
    seed = lfsr(seed);
    RX_SPL_BYTE0 <= seed[7:0];
    RX_SPL_BYTE1 <= seed[15:8];
    pulse(7'h08);
    rd(OFS_DEV_CAP, {22'h0, seed[9:8], seed[7:0]});
    wr(OFS_LINK_CTRL, 32'h1);
    L0S_COND <= 1'b1;
    tick(2);
    L0S_COND <= 1'b0;
    rd(OFS_STATUS, 32'h11);
    L0S_COND <= 1'b1;
    tick(8);
    rd(OFS_STATUS, 32'h12);
    L0S_COND <= 1'b0;
    pulse(7'h02);
    wr(OFS_LINK_CTRL, 32'h3);
    nak_mode <= 1'b1;
    L1_COND <= 1'b1;
    tick(12);
    L1_COND <= 1'b0;
    tick(8);
    rd(OFS_STATUS, 32'h11);
    nak_mode <= 1'b0;
    L1_COND <= 1'b1;
    tick(16);
    L1_COND <= 1'b0;
    rd(OFS_STATUS, 32'h13);
    pulse(7'h02);
    tick(6);
    wr(OFS_LINK_CTRL, 32'h0);
    wr(OFS_PM_STATE, 32'h1);
    tick(8);
    wr(OFS_PM_STATE, 32'h0);
    rd(OFS_STATUS, 32'h13);
    pulse(7'h02);
    tick(6);
    rd(OFS_STATUS, 32'h11);
    TX_VDM <= 1'b1;
    pulse(7'h20);
    TX_VDM <= 1'b0;
    chk(PORT_ACTIVITY_STATUS_N, 1'b1);
    pulse(7'h40);
    tick(HOLD / 2);
    pulse(7'h20);
    tick(HOLD - 4);
    chk(PORT_ACTIVITY_STATUS_N, 1'b0);
    tick(6);
    chk(PORT_ACTIVITY_STATUS_N, 1'b1);
    pulse(7'h01);
    rd(OFS_STATUS, 32'h0);
    chk(ROUTE_UR, 1'b1);
    pulse(7'h10);
    pulse(7'h04);
    rd(OFS_STATUS, 32'h05);
    chk(TRAFFIC_HOLD & CFG_ACCEPT, 1'b1);
    tick(2);
    tally_and_finish();
  end
endmodule : tb_lm_port_link_mgr
`default_nettype wire
